// >>> dv/bdc_image_model.sv
// Nonvolatile boot image and boot-mode pin seen from the loader
`timescale 1ns/1ns
`default_nettype none
module bdc_image_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic boot_image,
    input wire logic [3:0] delay,
    input wire logic [16:0] stored_cfg,
    input wire logic [7:0] stored_ver,
    input wire logic image_req,
    output logic boot_source_pin,
    output logic image_valid,
    output logic [16:0] image_cfg,
    output logic [7:0] image_version
);
    logic [3:0] wait_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= (image_req && wait_q != 4'hF) ? wait_q + 4'h1 : 4'h0;
        end
    end
    assign boot_source_pin = boot_image;
    assign image_valid = image_req && (wait_q >= delay);
    // No pull on the data lines: show the inverse while not valid
    assign image_cfg = image_valid ? stored_cfg : ~stored_cfg;
    assign image_version = image_valid ? stored_ver : ~stored_ver;
endmodule
`default_nettype wire

// >>> dv/test_bdc_loader.sv
// Self-checking bench for the boot configuration loader
`timescale 1ns/1ns
`default_nettype none
module test_bdc_loader;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata, slot_cycles;
    logic boot_image, boot_source_pin, boot_pin_enable, image_req, image_valid;
    logic [3:0] delay, pin_irq_masks;
    logic [16:0] stored_cfg, image_cfg;
    logic [7:0] stored_ver, image_version;
    logic hold_power_input, power_down_in, power_button_long, irq_raw, load_done;
    logic seq_start, rtc_ldo_off_power_sel, slow_clock_source_sel, keep_on_request;
    logic shutdown_req, core_reset_req, irq_out, supply_valid_start_mask;
    logic pin0_open_drain_en, supervisor_expired, divider_buffer_enable;
    logic power_down_active, hold_active, int_irq;
    int errors = 0;
    int n_compared = 0;
    bdc_loader #(.SLOT_SHORT(50), .SLOT_LONG(200), .WD_CYCLES(32'h40)) i_dut (.*);
    bdc_image_model i_img (.*);
    always #50 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Caller enters just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin
            errors++;
            summarize();
        end
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic boot(input logic img);
        int n;
        n = 0;
        boot_image <= img;
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        while (load_done !== 1'b1) begin
            @(posedge pclk);
            n++;
            if (n > 100) begin
                errors++;
                summarize();
            end
        end
        repeat (4) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic fixed_boot();
        boot(1'b0);
        check("boot_en", 0, 32'(boot_pin_enable));
        apb(1'b0, bdc_pkg::OFF_CFG, 0);
        check("cfg", 32'h0000C5B8, rdata);
        check("slot", 200, slot_cycles);
        check("rtc_clk", 0, {rtc_ldo_off_power_sel, slow_clock_source_sel});
        check("keep_on", 1, 32'(keep_on_request));
        check("hold", 0, 32'(hold_active));
        check("irq_out", 0, 32'(irq_out));
        check("sv_mask", 1, 32'(supply_valid_start_mask));
        check("pin_masks", 32'h5, 32'(pin_irq_masks));
        check("oden", 0, 32'(pin0_open_drain_en));
        check("div_buf", 0, 32'(divider_buffer_enable));
        check("pdn", 1, 32'(power_down_active));
        power_button_long <= 1'b1;
        repeat (4) @(posedge pclk);
        check("shutdown", 1, 32'(shutdown_req));
        check("core_rst", 1, 32'(core_reset_req));
    endtask
    task automatic image_boot();
        stored_cfg <= 17'h11A47;
        stored_ver <= 8'hC3;
        delay <= 4'h6;
        boot(1'b1);
        check("img_req", 0, 32'(image_req));
        apb(1'b0, bdc_pkg::OFF_CFG, 0);
        check("cfg", 32'h00011A47, rdata);
        apb(1'b0, bdc_pkg::OFF_VER, 0);
        check("ver", 32'hC3, rdata);
        check("slot", 50, slot_cycles);
        check("keep_on", 1, 32'(keep_on_request));
        check("hold", 1, 32'(hold_active));
        check("irq_out", 1, 32'(irq_out));
        check("pin_masks", 32'hA, 32'(pin_irq_masks));
        check("div_buf", 1, 32'(divider_buffer_enable));
        check("pdn", 0, 32'(power_down_active));
        check("shutdown", 0, 32'(shutdown_req));
    endtask
    task automatic regs_irq();
        int n;
        n = 0;
        apb(1'b0, 12'h020, 0);
        check("unmapped", 32'h1, {rdata[30:0], slverr});
        apb(1'b1, bdc_pkg::OFF_VER, 32'hFF);
        apb(1'b0, bdc_pkg::OFF_VER, 0);
        check("ver_ro", 32'hC3, rdata);
        apb(1'b1, bdc_pkg::OFF_CFG, 32'h13A47);
        while (supervisor_expired !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        check("wd_fired", 1, 32'(n > 40 && n < 200));
        apb(1'b1, bdc_pkg::OFF_CFG, 32'h11A47);
        apb(1'b1, bdc_pkg::OFF_IRQ_MASK, 0);
        check("irq_masked", 0, 32'(int_irq));
        apb(1'b1, bdc_pkg::OFF_IRQ_MASK, 32'h3);
        check("irq_set", 1, 32'(int_irq));
        apb(1'b0, bdc_pkg::OFF_IRQ_STAT, 0);
        check("stat", 32'h3, rdata & 32'h3);
        apb(1'b0, bdc_pkg::OFF_IRQ_STAT, 0);
        check("stat_clr", 0, rdata & 32'h3);
        check("irq_clr", 0, 32'(int_irq));
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        boot_image = 1'b0;
        delay = 4'h1;
        stored_cfg = 17'h00000;
        stored_ver = 8'h00;
        hold_power_input = 1'b1;
        power_down_in = 1'b0;
        power_button_long = 1'b0;
        irq_raw = 1'b1;
        fixed_boot();
        image_boot();
        regs_irq();
        summarize();
    end
endmodule
`default_nettype wire

// >>> rtl/bdc_loader.sv
// Boot default configuration loader with APB register access
`timescale 1ns/1ns
`default_nettype none
module bdc_loader #(
    parameter int SLOT_SHORT = bdc_pkg::SLOT_SHORT_CYC,
    parameter int SLOT_LONG = bdc_pkg::SLOT_LONG_CYC,
    parameter logic [31:0] WD_CYCLES = 32'(bdc_pkg::WD_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_source_pin,
    output logic boot_pin_enable,
    output logic image_req,
    input wire logic image_valid,
    input wire logic [16:0] image_cfg,
    input wire logic [7:0] image_version,
    input wire logic hold_power_input,
    input wire logic power_down_in,
    input wire logic power_button_long,
    input wire logic irq_raw,
    output logic load_done,
    output logic seq_start,
    output logic rtc_ldo_off_power_sel,
    output logic slow_clock_source_sel,
    output logic keep_on_request,
    output logic [31:0] slot_cycles,
    output logic shutdown_req,
    output logic core_reset_req,
    output logic irq_out,
    output logic supply_valid_start_mask,
    output logic [3:0] pin_irq_masks,
    output logic pin0_open_drain_en,
    output logic supervisor_expired,
    output logic divider_buffer_enable,
    output logic power_down_active,
    output logic hold_active,
    output logic int_irq
);
    ////////////////////////////////////////////////////////////////
    // Synchronisers
    logic [1:0] boot_s_q, img_s_q, hold_s_q, pd_s_q, lp_s_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_s_q <= 2'h0;
            img_s_q <= 2'h0;
            hold_s_q <= 2'h0;
            pd_s_q <= 2'h0;
            lp_s_q <= 2'h0;
        end else begin
            boot_s_q <= {boot_s_q[0], boot_source_pin};
            img_s_q <= {img_s_q[0], image_valid};
            hold_s_q <= {hold_s_q[0], hold_power_input};
            pd_s_q <= {pd_s_q[0], power_down_in};
            lp_s_q <= {lp_s_q[0], power_button_long};
        end
    end
    ////////////////////////////////////////////////////////////////
    // Boot state machine
    bdc_pkg::bdc_state_e st_q, st_d;
    logic [1:0] wait_q;
    logic [16:0] cfg_q;
    logic [7:0] ver_q;
    logic pin_en_q;
    wire waited = (wait_q == 2'h3);
    wire go_fetch = (st_q == bdc_pkg::ST_SAMPLE) && waited && boot_s_q[1];
    wire go_fixed = (st_q == bdc_pkg::ST_SAMPLE) && waited && !boot_s_q[1];
    wire fetch_ok = (st_q == bdc_pkg::ST_FETCH) && img_s_q[1];
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire wr_cfg = wr && (paddr == bdc_pkg::OFF_CFG) && (st_q == bdc_pkg::ST_DONE);
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            bdc_pkg::ST_SAMPLE: begin
                if (waited) st_d = boot_s_q[1] ? bdc_pkg::ST_FETCH : bdc_pkg::ST_DONE;
            end
            bdc_pkg::ST_FETCH: begin
                if (img_s_q[1]) st_d = bdc_pkg::ST_DONE;
            end
            bdc_pkg::ST_DONE: st_d = bdc_pkg::ST_DONE;
            default: st_d = bdc_pkg::ST_SAMPLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= bdc_pkg::ST_SAMPLE;
            wait_q <= 2'h0;
            pin_en_q <= 1'b1;
            cfg_q <= bdc_pkg::CFG_FIXED;
            ver_q <= bdc_pkg::VER_FIXED;
        end else begin
            st_q <= st_d;
            if (!waited) wait_q <= wait_q + 2'h1;
            if (go_fetch || go_fixed) pin_en_q <= 1'b0;
            if (fetch_ok) begin
                cfg_q <= image_cfg;
                ver_q <= image_version;
            end else if (wr_cfg) begin
                cfg_q <= pwdata[16:0];
            end
        end
    end
    assign boot_pin_enable = pin_en_q;
    assign image_req = (st_q == bdc_pkg::ST_FETCH);
    assign load_done = (st_q == bdc_pkg::ST_DONE);
    logic seq_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seq_q <= 1'b0;
        else seq_q <= (st_d == bdc_pkg::ST_DONE) && (st_q != bdc_pkg::ST_DONE);
    end
    assign seq_start = seq_q;
    ////////////////////////////////////////////////////////////////
    // Decoded settings; rtc, clock, keep-on, hold, shutdown, reset and power-down outputs gated until loading is done
    wire d = load_done;
    assign rtc_ldo_off_power_sel = d && cfg_q[bdc_pkg::B_RTC];
    assign slow_clock_source_sel = d && cfg_q[bdc_pkg::B_CLK];
    assign keep_on_request = d && (cfg_q[bdc_pkg::B_KEEP] || cfg_q[bdc_pkg::B_AUTO]);
    assign hold_active = d && !cfg_q[bdc_pkg::B_AUTO] && hold_s_q[1];
    assign slot_cycles = cfg_q[bdc_pkg::B_SLOT] ? 32'(SLOT_LONG) : 32'(SLOT_SHORT);
    assign shutdown_req = d && cfg_q[bdc_pkg::B_LPOFF] && lp_s_q[1];
    assign core_reset_req = d && cfg_q[bdc_pkg::B_LPRST] && shutdown_req;
    assign irq_out = irq_raw ~^ cfg_q[bdc_pkg::B_IPOL];
    assign supply_valid_start_mask = cfg_q[bdc_pkg::B_SVMSK];
    assign pin_irq_masks = cfg_q[bdc_pkg::B_P4R:bdc_pkg::B_P5F];
    assign pin0_open_drain_en = cfg_q[bdc_pkg::B_ODEN];
    assign divider_buffer_enable = !cfg_q[bdc_pkg::B_BYP];
    assign power_down_active = d && (pd_s_q[1] == cfg_q[bdc_pkg::B_PDPOL]);
    ////////////////////////////////////////////////////////////////
    // Periodic supervisor; a write with bit 0 set to the control register kicks it
    logic [31:0] wd_q;
    logic wd_exp_q;
    wire kick = wr && (paddr == bdc_pkg::OFF_CTRL) && pwdata[0];
    wire wd_on = d && cfg_q[bdc_pkg::B_WDEN];
    wire wd_hit = wd_on && (wd_q == WD_CYCLES - 32'h1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_q <= 32'h0;
            wd_exp_q <= 1'b0;
        end else begin
            wd_exp_q <= wd_hit;
            if (!wd_on || kick || wd_hit) wd_q <= 32'h0;
            else wd_q <= wd_q + 32'h1;
        end
    end
    assign supervisor_expired = wd_exp_q;
    ////////////////////////////////////////////////////////////////
    // Sticky interrupts, cleared by reading status; set wins
    logic [2:0] ist_q, imsk_q;
    logic lp_seen_q;
    wire [2:0] ev = {shutdown_req && !lp_seen_q, wd_exp_q, seq_q};
    wire rd_ist = rd && (paddr == bdc_pkg::OFF_IRQ_STAT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= 3'h0;
            imsk_q <= 3'h0;
            lp_seen_q <= 1'b0;
        end else begin
            lp_seen_q <= shutdown_req;
            ist_q <= (rd_ist ? 3'h0 : ist_q) | ev;
            if (wr && paddr == bdc_pkg::OFF_IRQ_MASK) imsk_q <= pwdata[2:0];
        end
    end
    assign int_irq = |(ist_q & imsk_q);
    ////////////////////////////////////////////////////////////////
    // APB read mux, zero-wait
    wire mapped = (paddr == bdc_pkg::OFF_CFG) || (paddr == bdc_pkg::OFF_STAT) ||
        (paddr == bdc_pkg::OFF_IRQ_STAT) || (paddr == bdc_pkg::OFF_IRQ_MASK) ||
        (paddr == bdc_pkg::OFF_VER) || (paddr == bdc_pkg::OFF_CTRL);
    wire [31:0] rmux =
        (paddr == bdc_pkg::OFF_CFG) ? {15'h0, cfg_q} :
        (paddr == bdc_pkg::OFF_STAT) ? {28'h0, boot_s_q[1], st_q, d} :
        (paddr == bdc_pkg::OFF_IRQ_STAT) ? {29'h0, ist_q} :
        (paddr == bdc_pkg::OFF_IRQ_MASK) ? {29'h0, imsk_q} :
        (paddr == bdc_pkg::OFF_VER) ? {24'h0, ver_q} : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0;
        else if (psel && !penable && !pwrite) prdata <= rmux;
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    ////////////////////////////////////////////////////////////////
    // Checks: boot pin and loading
    a_pin_off: assert property (
        @(posedge pclk) disable iff (!presetn) (st_q != bdc_pkg::ST_SAMPLE) |-> !boot_pin_enable)
        else $error("boot pin still on");

    a_pin_once: assert property (
        @(posedge pclk) disable iff (!presetn) !boot_pin_enable |=> !boot_pin_enable)
        else $error("boot pin enabled again");

    a_pin_sample: assert property (
        @(posedge pclk) disable iff (!presetn) (st_q == bdc_pkg::ST_SAMPLE) |-> boot_pin_enable)
        else $error("boot pin off before sampling");

    a_fixed_cfg: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_q == bdc_pkg::ST_SAMPLE) |-> (cfg_q == bdc_pkg::CFG_FIXED))
        else $error("settings not fixed defaults");

    a_img_load: assert property (
        @(posedge pclk) disable iff (!presetn) fetch_ok |=> (cfg_q == $past(image_cfg)))
        else $error("image not loaded");

    a_ver_load: assert property (
        @(posedge pclk) disable iff (!presetn) fetch_ok |=> (ver_q == $past(image_version)))
        else $error("version not loaded");

    a_ver_ro: assert property (
        @(posedge pclk) disable iff (!presetn) (st_q == bdc_pkg::ST_DONE) |=> $stable(ver_q))
        else $error("version changed after load");

    a_cfg_lock: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((st_q != bdc_pkg::ST_DONE) && !fetch_ok) |=> $stable(cfg_q))
        else $error("settings changed while loading");

    a_seq_after: assert property (
        @(posedge pclk) disable iff (!presetn) seq_start |-> load_done)
        else $error("sequence before load");

    a_seq_pulse: assert property (
        @(posedge pclk) disable iff (!presetn) seq_start |=> !seq_start)
        else $error("sequence start too long");

    a_req_fetch: assert property (
        @(posedge pclk) disable iff (!presetn) image_req |-> !load_done)
        else $error("image request after load");

    a_done_hold: assert property (
        @(posedge pclk) disable iff (!presetn) load_done |=> load_done)
        else $error("load done dropped");

    ////////////////////////////////////////////////////////////////
    // Checks: decoded settings
    a_rtc_gate: assert property (
        @(posedge pclk) disable iff (!presetn) !load_done |-> !rtc_ldo_off_power_sel)
        else $error("rtc select before load");

    a_rtc_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        load_done |-> (rtc_ldo_off_power_sel == cfg_q[bdc_pkg::B_RTC]))
        else $error("rtc select");

    a_clk_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        load_done |-> (slow_clock_source_sel == cfg_q[bdc_pkg::B_CLK]))
        else $error("slow clock select");

    a_keep_req: assert property (
        @(posedge pclk) disable iff (!presetn) (d && cfg_q[bdc_pkg::B_KEEP]) |-> keep_on_request)
        else $error("keep-on request");

    a_keep_auto: assert property (
        @(posedge pclk) disable iff (!presetn) (d && cfg_q[bdc_pkg::B_AUTO]) |-> keep_on_request)
        else $error("auto keep-on");

    a_hold_auto: assert property (
        @(posedge pclk) disable iff (!presetn) cfg_q[bdc_pkg::B_AUTO] |-> !hold_active)
        else $error("hold active in auto mode");

    a_slot_len: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cfg_q[bdc_pkg::B_SLOT] |-> (slot_cycles == 32'(SLOT_SHORT)))
        else $error("short slot");

    a_slot_long: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg_q[bdc_pkg::B_SLOT] |-> (slot_cycles == 32'(SLOT_LONG)))
        else $error("long slot");

    a_lp_off: assert property (
        @(posedge pclk) disable iff (!presetn) !cfg_q[bdc_pkg::B_LPOFF] |-> !shutdown_req)
        else $error("shutdown not allowed");

    a_lp_on: assert property (
        @(posedge pclk) disable iff (!presetn)
        (d && cfg_q[bdc_pkg::B_LPOFF] && lp_s_q[1]) |-> shutdown_req)
        else $error("shutdown missing");

    a_rst_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        core_reset_req |-> (shutdown_req && cfg_q[bdc_pkg::B_LPRST]))
        else $error("core reset without shutdown");

    a_irq_pol: assert property (
        @(posedge pclk) disable iff (!presetn) (!cfg_q[bdc_pkg::B_IPOL] && irq_raw) |-> !irq_out)
        else $error("irq polarity");

    a_irq_high: assert property (
        @(posedge pclk) disable iff (!presetn) (cfg_q[bdc_pkg::B_IPOL] && irq_raw) |-> irq_out)
        else $error("irq active high");

    a_irq_idle: assert property (
        @(posedge pclk) disable iff (!presetn) !irq_raw |-> (irq_out == !cfg_q[bdc_pkg::B_IPOL]))
        else $error("irq idle level");

    a_sv_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        supply_valid_start_mask == cfg_q[bdc_pkg::B_SVMSK])
        else $error("supply start mask");

    a_pin_masks: assert property (
        @(posedge pclk) disable iff (!presetn)
        pin_irq_masks == cfg_q[bdc_pkg::B_P4R:bdc_pkg::B_P5F])
        else $error("pin edge masks");

    a_oden: assert property (
        @(posedge pclk) disable iff (!presetn) pin0_open_drain_en == cfg_q[bdc_pkg::B_ODEN])
        else $error("pin0 drive type");

    a_wd_off: assert property (
        @(posedge pclk) disable iff (!presetn) !wd_on |=> !supervisor_expired)
        else $error("supervisor off fired");

    a_wd_pulse: assert property (
        @(posedge pclk) disable iff (!presetn) supervisor_expired |=> !supervisor_expired)
        else $error("supervisor pulse too long");

    a_div_buf: assert property (
        @(posedge pclk) disable iff (!presetn) divider_buffer_enable != cfg_q[bdc_pkg::B_BYP])
        else $error("divider buffer");

    a_pd_pol: assert property (
        @(posedge pclk) disable iff (!presetn)
        (d && !cfg_q[bdc_pkg::B_PDPOL] && !pd_s_q[1]) |-> power_down_active)
        else $error("power down polarity");

    a_pd_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        (d && cfg_q[bdc_pkg::B_PDPOL] && pd_s_q[1]) |-> power_down_active)
        else $error("power down active high");

    ////////////////////////////////////////////////////////////////
    // Checks: registers and interrupts
    a_ist_set: assert property (
        @(posedge pclk) disable iff (!presetn) (|ev) |=> ((ist_q & $past(ev)) == $past(ev)))
        else $error("status event lost");

    a_cfg_mapped: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && (paddr == bdc_pkg::OFF_CFG)) |-> !pslverr)
        else $error("settings register refused");
endmodule
`default_nettype wire

// >>> shared/bdc_pkg.sv
// Constants and types for the boot default configuration loader
package bdc_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CFG = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
    localparam logic [11:0] OFF_VER = 12'h010;
    localparam logic [11:0] OFF_CTRL = 12'h014;
    // Config word field positions
    localparam int B_RTC = 0;
    localparam int B_CLK = 1;
    localparam int B_KEEP = 2;
    localparam int B_SLOT = 3;
    localparam int B_LPOFF = 4;
    localparam int B_LPRST = 5;
    localparam int B_IPOL = 6;
    localparam int B_SVMSK = 7;
    localparam int B_P5F = 8;
    localparam int B_P5R = 9;
    localparam int B_P4F = 10;
    localparam int B_P4R = 11;
    localparam int B_ODEN = 12;
    localparam int B_WDEN = 13;
    localparam int B_BYP = 14;
    localparam int B_AUTO = 15;
    localparam int B_PDPOL = 16;
    localparam int CFG_W = 17;
    // Fixed-boot defaults; rising mask of pin4 and supervisor left 0
    localparam logic [16:0] CFG_FIXED = 17'h0C5B8;
    localparam logic [7:0] VER_FIXED = 8'h5A; // Arbitrary value
    // Timing
    localparam int CLK_HZ = 10000000;
    localparam int SLOT_SHORT_US = 500;
    localparam int SLOT_LONG_US = 2000;
    localparam int SLOT_SHORT_CYC = SLOT_SHORT_US * (CLK_HZ / 1000000);
    localparam int SLOT_LONG_CYC = SLOT_LONG_US * (CLK_HZ / 1000000);
    localparam int WD_PERIOD_S = 100;
    localparam longint WD_CYC = longint'(WD_PERIOD_S) * longint'(CLK_HZ);
    // Status/irq bits
    localparam int I_LOADED = 0;
    localparam int I_WD = 1;
    localparam int I_LP = 2;
    typedef enum logic [1:0] {
        ST_SAMPLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_DONE = 2'b10
    } bdc_state_e;
endpackage
